// ===== pkg/bsc_map.vh
`ifndef BSC_MAP_VH
`define BSC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BSC_OFF_CFG   12'h000
`define BSC_OFF_STAT  12'h004
`define BSC_OFF_CNT   12'h008

// ----------------------------------------
// Configuration fields and reset value
// ----------------------------------------
`define BSC_CFG_ILV   0
`define BSC_CFG_BM    1
`define BSC_CFG_PRE2  3
`define BSC_CFG_AL    4
`define BSC_CFG_RL    8
`define BSC_CFG_WL    16
`define BSC_CFG_RST   32'h000C_1000

// ----------------------------------------
// Burst modes, latency modes, commands
// ----------------------------------------
`define BSC_BM_BL8    2'h0
`define BSC_BM_BC4    2'h1
`define BSC_BM_OTF    2'h2
`define BSC_AL_ZERO   2'h0
`define BSC_AL_M1     2'h1
`define BSC_AL_M2     2'h2
`define BSC_CMD_RD    3'h5
`define BSC_CMD_WR    3'h4
`define BSC_CMD_PRE   3'h2

// ----------------------------------------
// Timing counts, in link clock edges
// ----------------------------------------
`define BSC_BEATS_BL8 4'h8
`define BSC_BEATS_BC4 4'h4

`endif

// ===== rtl/bsc_buf2.v
`timescale 1ns/1ns
// Two-entry buffer with valid/ready on both sides
module bsc_buf2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];   // Storage
  reg         wp_q;          // Write pointer
  reg         rp_q;          // Read pointer
  reg [1:0]   cnt_q;         // Occupancy
  wire        push;          // Accepted write
  wire        pop;           // Accepted read

  // Full stalls the source, empty holds the sink
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ----------------------------------------
  // Storage write, no reset needed
  // ----------------------------------------
  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // ----------------------------------------
  // Pointers and count
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      // Simultaneous push and pop keep the count
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// ===== rtl/bsc_device.v
`timescale 1ns/1ns
`include "bsc_map.vh"
// Banked DRAM command and burst access, device end
module bsc_device #(
  parameter ROWB = 2,   // Row bits kept in the array
  parameter COLB = 4    // Column bits kept in the array
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  input  wire        ck,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        activate_strobe_n,
  input  wire        row_strobe_or_addr16,
  input  wire        column_strobe_or_addr15,
  input  wire        write_strobe_or_addr14,
  input  wire [1:0]  bank_group_select,
  input  wire [1:0]  bank_select,
  input  wire [13:0] row_address_bits,
  input  wire [7:0]  dq_in,
  output wire [7:0]  dq_out,
  output wire        dq_oe,
  input  wire        write_mask_n,
  output wire        dqs_out,
  output wire        dqs_oe
);
  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam MAW    = 4 + ROWB + COLB;   // Array index width
  localparam SW     = 34;                // Synchronised pin count
  localparam S_IDLE = 3'b001;            // No burst
  localparam S_WAIT = 3'b010;            // Latency countdown
  localparam S_XFER = 3'b100;            // Data beats

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Column of beat i, wrapping inside the burst
  function [9:0] burst_col;
    input [9:0] start;
    input [2:0] i;
    input       ilv;
    begin
      if (ilv) begin
        burst_col = {start[9:3], start[2:0] ^ i};
      end else begin
        burst_col = {start[9:3], start[2] ^ i[2],
                     start[1:0] + i[1:0]};
      end
    end
  endfunction

  // Array index from bank, row and column
  function [MAW-1:0] mem_idx;
    input [3:0]  bank;
    input [16:0] row;
    input [9:0]  col;
    begin
      mem_idx = {bank, row[ROWB-1:0], col[COLB-1:0]};
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [SW-1:0] s1_q;            // First sync stage
  reg  [SW-1:0] s2_q;            // Second sync stage
  reg           ck3_q;           // Link clock history
  reg  [31:0]   cfg_q;           // Configuration
  reg  [31:0]   prdata_q;        // Read data
  reg  [15:0]   acc_cnt_q;       // Accepted commands
  reg  [15:0]   ign_cnt_q;       // Ignored commands
  reg  [15:0]   open_q;          // Banks with an open row
  reg  [16:0]   row_q [0:15];    // Open row per bank
  reg  [7:0]    mem_q [0:(1<<MAW)-1]; // Cell array
  reg  [2:0]    st_q;            // Burst engine state
  reg           rd_q;            // Burst is a read
  reg           ap_q;            // Auto-precharge pending
  reg  [3:0]    beats_q;         // Beats in burst
  reg  [3:0]    beat_q;          // Beats done
  reg  [3:0]    fetch_q;         // Beats fetched
  reg  [7:0]    lat_q;           // Edges left in latency
  reg  [9:0]    col_q;           // Start column
  reg  [3:0]    bank_q;          // Burst bank
  reg  [7:0]    dq_q;            // Driven data
  reg           dqs_q;           // Driven strobe level
  wire          ck_s;            // Synchronised link clock
  wire          rise;            // Link clock rising
  wire          edge_any;        // Either link clock edge
  wire          s_cke;
  wire          s_cs_n;
  wire          s_act_n;
  wire [2:0]    s_cmd;           // Command pins
  wire [3:0]    s_bank;          // Group and bank
  wire [13:0]   s_addr;
  wire [7:0]    s_dq;
  wire          s_dm_n;
  wire          auto_precharge_flag;
  wire          burst_chop_select;
  wire          cmd_edge;        // Selected command edge
  wire          rw_ok;           // Read/write to open bank
  wire          beat;            // Beat edge in transfer
  wire [1:0]    bm;              // Burst mode field
  wire [4:0]    rl;              // Read latency
  wire [4:0]    al;              // Additive latency
  wire [5:0]    lat_r;           // Total read latency
  wire [5:0]    lat_w;           // Total write latency
  wire          rdm;             // Register read decode
  wire          unmapped;        // Address hits nothing
  wire          fe_valid;        // Fetch wants a slot
  wire          fe_ready;        // Buffer has a slot
  wire [7:0]    fe_data;         // Fetched byte
  wire          bo_valid;        // Buffer holds a byte
  wire [7:0]    bo_data;         // Buffer head
  wire [9:0]    fcol;            // Column being fetched
  wire [9:0]    wcol;            // Column being written

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Every pin crosses two flops before any use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= {SW{1'b0}};
      s2_q  <= {SW{1'b0}};
      ck3_q <= 1'b0;
    end else begin
      s1_q  <= {ck, cke, cs_n, activate_strobe_n,
                row_strobe_or_addr16,
                column_strobe_or_addr15,
                write_strobe_or_addr14,
                bank_group_select, bank_select,
                row_address_bits, dq_in, write_mask_n};
      s2_q  <= s1_q;
      ck3_q <= s2_q[SW-1];
    end
  end

  // Field split of the second stage
  assign ck_s     = s2_q[33];
  assign s_cke    = s2_q[32];
  assign s_cs_n   = s2_q[31];
  assign s_act_n  = s2_q[30];
  assign s_cmd    = s2_q[29:27];
  assign s_bank   = s2_q[26:23];
  assign s_addr   = s2_q[22:9];
  assign s_dq     = s2_q[8:1];
  assign s_dm_n   = s2_q[0];
  assign rise     = ck_s & ~ck3_q;
  assign edge_any = ck_s ^ ck3_q;

  // Pin aliases for the two flag bits
  assign auto_precharge_flag = s_addr[10];
  assign burst_chop_select   = s_addr[12];

  // Command taken only when selected and clocked
  assign cmd_edge = rise & ~s_cs_n & s_cke;
  // Closed banks refuse column commands
  assign rw_ok    = open_q[s_bank];

  // ----------------------------------------
  // Latency arithmetic
  // ----------------------------------------
  assign bm = cfg_q[`BSC_CFG_BM+1:`BSC_CFG_BM];
  assign rl = cfg_q[`BSC_CFG_RL+4:`BSC_CFG_RL];
  // Additive latency tracks read latency
  assign al =
    (cfg_q[`BSC_CFG_AL+1:`BSC_CFG_AL] == `BSC_AL_M1) ?
      rl - 5'h01 :
    (cfg_q[`BSC_CFG_AL+1:`BSC_CFG_AL] == `BSC_AL_M2) ?
      rl - 5'h02 : 5'h00;
  assign lat_r = {1'b0, al} + {1'b0, rl};
  assign lat_w = {1'b0, al} +
                 {1'b0, cfg_q[`BSC_CFG_WL+4:`BSC_CFG_WL]};

  // ----------------------------------------
  // Bank state
  // ----------------------------------------
  // Activate latches the row, precharge closes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 16'h0000;
    end else begin
      if (cmd_edge & ~s_act_n) begin
        open_q[s_bank] <= 1'b1;
      end else if (cmd_edge &&
                   s_cmd == `BSC_CMD_PRE) begin
        // Bit 10 selects all banks
        if (auto_precharge_flag) begin
          open_q <= 16'h0000;
        end else begin
          open_q[s_bank] <= 1'b0;
        end
      end
      // Burst end with auto-precharge closes bank
      if (beat && beat_q == beats_q - 4'h1 && ap_q) begin
        open_q[bank_q] <= 1'b0;
      end
    end
  end

  // Row storage, no reset: only valid when open
  always @(posedge pclk) begin
    if (cmd_edge & ~s_act_n) begin
      // Command pins carry row bits 16..14 here
      row_q[s_bank] <= {s_cmd, s_addr};
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  assign beat = edge_any & st_q[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= S_IDLE;
      rd_q    <= 1'b0;
      ap_q    <= 1'b0;
      beats_q <= `BSC_BEATS_BL8;
      beat_q  <= 4'h0;
      lat_q   <= 8'h00;
      col_q   <= 10'h000;
      bank_q  <= 4'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          // Activate-low means a row, not a command
          if (cmd_edge && s_act_n && rw_ok &&
              (s_cmd == `BSC_CMD_RD ||
               s_cmd == `BSC_CMD_WR)) begin
            st_q   <= S_WAIT;
            rd_q   <= (s_cmd == `BSC_CMD_RD);
            ap_q   <= auto_precharge_flag;
            col_q  <= s_addr[9:0];
            bank_q <= s_bank;
            beat_q <= 4'h0;
            // Two edges per link clock of latency
            lat_q  <= (s_cmd == `BSC_CMD_RD) ?
                      {1'b0, lat_r, 1'b0} :
                      {1'b0, lat_w, 1'b0};
            // Chop fixed, or per command by bit 12
            if (bm == `BSC_BM_BC4 ||
                (bm == `BSC_BM_OTF &&
                 !burst_chop_select)) begin
              beats_q <= `BSC_BEATS_BC4;
            end else begin
              beats_q <= `BSC_BEATS_BL8;
            end
          end
        end
        S_WAIT: begin
          // Count edges down to the first beat
          if (lat_q <= 8'h01) begin
            st_q <= S_XFER;
          end else if (edge_any) begin
            lat_q <= lat_q - 8'h01;
            if (lat_q == 8'h02) begin
              st_q <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (beat) begin
            beat_q <= beat_q + 4'h1;
            // One edge past the last beat holds it out
            if (beat_q == beats_q) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  assign wcol = burst_col(col_q, beat_q[2:0],
                          cfg_q[`BSC_CFG_ILV]);

  // Masked beats leave the cell untouched
  always @(posedge pclk) begin
    if (beat && !rd_q && s_dm_n &&
        beat_q != beats_q) begin
      mem_q[mem_idx(bank_q, row_q[bank_q], wcol)] <= s_dq;
    end
  end

  // ----------------------------------------
  // Read path: fetch into two-entry buffer
  // ----------------------------------------
  // Fetch runs ahead; a full buffer stalls it
  assign fcol     = burst_col(col_q, fetch_q[2:0],
                              cfg_q[`BSC_CFG_ILV]);
  assign fe_valid = rd_q & ~st_q[0] & (fetch_q < beats_q);
  assign fe_data  = mem_q[mem_idx(bank_q, row_q[bank_q],
                                  fcol)];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_q <= 4'h0;
    end else if (st_q[0]) begin
      fetch_q <= 4'h0;
    end else if (fe_valid & fe_ready) begin
      fetch_q <= fetch_q + 4'h1;
    end
  end

  bsc_buf2 #(
    .W (8)
  ) u_buf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (fe_valid),
    .in_ready  (fe_ready),
    .in_data   (fe_data),
    .out_valid (bo_valid),
    .out_ready (beat & rd_q),
    .out_data  (bo_data)
  );

  // Output beat register and strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_q  <= 8'h00;
      dqs_q <= 1'b0;
    end else if (beat & rd_q) begin
      // Buffer fills long before each beat edge
      if (bo_valid) begin
        dq_q <= bo_data;
      end
      dqs_q <= ~ck_s;
    end else if (~st_q[2]) begin
      dqs_q <= 1'b0;
    end
  end

  assign dq_out = dq_q;
  // Enable rises with the first byte
  assign dq_oe  = rd_q & st_q[2] & (beat_q != 4'h0);
  assign dqs_out = dqs_q;
  // Strobe driven low for one or two clocks first
  assign dqs_oe = rd_q & (st_q[2] |
                  (st_q[1] &&
                   lat_q <= (cfg_q[`BSC_CFG_PRE2] ?
                             8'h04 : 8'h02)));

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign unmapped = (paddr != `BSC_OFF_CFG) &&
                    (paddr != `BSC_OFF_STAT) &&
                    (paddr != `BSC_OFF_CNT);
  assign rdm      = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & unmapped;
  assign prdata   = prdata_q;

  // Read data captured in setup, stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rdm) begin
      case (paddr)
        `BSC_OFF_CFG:  prdata_q <= cfg_q;
        `BSC_OFF_STAT: prdata_q <= {13'h0000, st_q,
                                     open_q};
        `BSC_OFF_CNT:  prdata_q <= {ign_cnt_q, acc_cnt_q};
        default:       prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration write in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `BSC_CFG_RST;
    end else if (psel && penable && pwrite &&
                 paddr == `BSC_OFF_CFG) begin
      cfg_q <= pwdata & 32'h001F_1F3F;
    end
  end

  // ----------------------------------------
  // Command counters
  // ----------------------------------------
  // Deselected edges count as ignored commands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_q <= 16'h0000;
      ign_cnt_q <= 16'h0000;
    end else begin
      if (cmd_edge) begin
        acc_cnt_q <= acc_cnt_q + 16'h0001;
      end
      if (rise & s_cs_n & s_cke) begin
        ign_cnt_q <= ign_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// ===== testbench/bsc_device_monitor.sv
`timescale 1ns/1ns
// Port checks on the register bus and the read data pins
module bsc_device_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire [7:0]  dq_out,
  input wire        dq_oe,
  input wire        dqs_out,
  input wire        dqs_oe
);
  // ------------------------------
  // Helpers
  // ------------------------------
  wire        map_w;  // Address hits one of the three registers
  logic [5:0] run_q;  // Cycles the data pins have been driven so far
  assign map_w = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
  // Run length of a burst, held until the cycle after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_q <= 6'h00;
    else if (dq_oe)
      run_q <= run_q + 6'h01;
    else
      run_q <= 6'h00;
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("Access phase without ready");
  a_err_map: assert property (psel && penable |-> pslverr == !map_w)
    else $error("Error response does not match the address");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("Error response outside an access");
  a_rdata_zero: assert property (psel && penable && !pwrite && !map_w
    |-> prdata == 32'h0) else $error("Unmapped read data not zero");
  a_oe_pair: assert property (dq_oe |-> dqs_oe)
    else $error("Data driven without strobe");
  a_preamble_quiet: assert property ($rose(dqs_oe) |-> !dq_oe [*7])
    else $error("Data before the strobe preamble ended");
  a_preamble_lead: assert property ($rose(dq_oe) |-> $past(dqs_oe, 7))
    else $error("Data started without a strobe preamble");
  a_beat_hold: assert property (dq_oe && $changed(dq_out)
    |=> $stable(dq_out) [*3]) else $error("Beat shorter than half a clock");
  a_strobe_toggle: assert property (dq_oe && $past(dq_oe, 4)
    |-> dqs_out != $past(dqs_out, 4)) else $error("Strobe missed a beat");
  a_burst_len: assert property ($fell(dq_oe)
    |-> run_q == 6'h10 || run_q == 6'h20) else $error("Burst length wrong");
  // Main scenarios reached
  c_read: cover property ($rose(dq_oe));
  c_chop: cover property ($fell(dq_oe) && run_q == 6'h10);
  c_error: cover property (pslverr);
endmodule
bind bsc_device bsc_device_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .dq_out(dq_out),
  .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// ===== testbench/bsc_ctrl_model.sv
`timescale 1ns/1ns
// Controller stand-in: link clock, commands and write beats
module bsc_ctrl_model #(
  parameter int WLAT = 12  // Write latency in link clocks
) (
  input  wire         pclk,
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        activate_strobe_n,
  output logic        row_strobe_or_addr16,
  output logic        column_strobe_or_addr15,
  output logic        write_strobe_or_addr14,
  output logic [1:0]  bank_group_select,
  output logic [1:0]  bank_select,
  output logic [13:0] row_address_bits,
  output logic [7:0]  dq_in,
  output logic        write_mask_n
);
  time        cmd_t;  // Moment of the last command clock edge
  logic       bt_on;  // Beat window open
  logic [7:0] bt_d;   // Byte for the coming beat
  logic       bt_m;   // Keep flag for the coming beat
  // Clock runs free: read beats need edges long after the command
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, activate_strobe_n} = 2'h3;
    {row_strobe_or_addr16, column_strobe_or_addr15} = 2'h3;
    write_strobe_or_addr14 = 1'b1;
    {bank_group_select, bank_select, row_address_bits} = 18'h0;
    {bt_on, bt_d, bt_m} = 10'h000;
    #13;
    forever #160 ck = ~ck;
  end
  // Idle data lines show the inverse of the last byte
  always @(posedge pclk) begin
    dq_in <= bt_on ? bt_d : ~bt_d;
    write_mask_n <= bt_on ? bt_m : 1'b1;
  end
  // One command, steady across the rising link edge
  task automatic cmd(input logic sel_n, input logic act_n,
                     input logic [2:0] code, input logic [3:0] bank,
                     input logic [13:0] a);
    @(negedge ck);
    @(posedge pclk);
    cs_n <= sel_n;
    activate_strobe_n <= act_n;
    {row_strobe_or_addr16, column_strobe_or_addr15,
     write_strobe_or_addr14} <= code;
    {bank_group_select, bank_select} <= bank;
    row_address_bits <= a;
    @(posedge ck);
    cmd_t = $time;
    @(negedge ck);
    @(posedge pclk);
    cs_n <= 1'b1;
    activate_strobe_n <= 1'b1;
    {row_strobe_or_addr16, column_strobe_or_addr15,
     write_strobe_or_addr14} <= ~code;
    {bank_group_select, bank_select} <= ~bank;
    row_address_bits <= ~a;
  endtask
  // Write command, then eight bytes placed mid-way between edges
  task automatic wr(input logic [3:0] bank, input logic [13:0] a,
                    input logic [63:0] d, input logic [7:0] m);
    int b;
    cmd(1'b0, 1'b1, 3'h4, bank, a);
    for (int e = 1; e < 32; e++) begin
      if (e > 1)
        @(ck);
      repeat (2) @(posedge pclk);
      b = e + 1 - 2 * WLAT;
      bt_on <= b >= 0 && b < 8;
      bt_d <= d[8 * (b & 7) +: 8];
      bt_m <= m[b & 7];
    end
    repeat (16) @(posedge pclk);
  endtask
endmodule

// ===== testbench/bsc_device_tb.sv
`timescale 1ns/1ns
// Self-checking bench: register bus and link traffic
module bsc_device_tb;
  // ------------------------------
  // Signals
  // ------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr, ck, cke, cs_n, activate_strobe_n, write_mask_n;
  logic        row_strobe_or_addr16, column_strobe_or_addr15;
  logic        write_strobe_or_addr14, dq_oe, dqs_out, dqs_oe;
  logic [1:0]  bank_group_select, bank_select;
  logic [13:0] row_address_bits;
  logic [7:0]  dq_in, dq_out;
  logic [15:0] cnt0;
  logic [7:0]  got[$];  // Bytes of the last read burst
  time         rise_t, pre_t;
  int          failures, samples_checked, lat[3];
  bsc_device i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .ck(ck),
    .cke(cke), .cs_n(cs_n), .activate_strobe_n(activate_strobe_n),
    .row_strobe_or_addr16(row_strobe_or_addr16),
    .column_strobe_or_addr15(column_strobe_or_addr15),
    .write_strobe_or_addr14(write_strobe_or_addr14),
    .bank_group_select(bank_group_select), .bank_select(bank_select),
    .row_address_bits(row_address_bits), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .write_mask_n(write_mask_n), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe));
  bsc_ctrl_model i_ctl (.pclk(pclk), .ck(ck), .cke(cke), .cs_n(cs_n),
    .activate_strobe_n(activate_strobe_n),
    .row_strobe_or_addr16(row_strobe_or_addr16),
    .column_strobe_or_addr15(column_strobe_or_addr15),
    .write_strobe_or_addr14(write_strobe_or_addr14),
    .bank_group_select(bank_group_select), .bank_select(bank_select),
    .row_address_bits(row_address_bits), .dq_in(dq_in),
    .write_mask_n(write_mask_n));
  // ------------------------------
  // Clock, capture, watchdog
  // ------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Beats are taken at the next link edge, where they are settled
  always @(ck) begin
    if (dq_oe === 1'b1)
      got.push_back(dq_out);
  end
  always @(posedge dq_oe) rise_t = $time;
  always @(posedge dqs_oe) pre_t = $time;
  initial begin
    #2000000;
    failures++;
    end_sim();
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer; waits for ready rather than assuming it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read command, then wait (bounded) for the burst to finish
  task automatic rd(input logic sel_n, input logic [3:0] b,
                    input logic [13:0] a);
    got.delete();
    i_ctl.cmd(sel_n, 1'b1, 3'h5, b, a);
    for (int k = 0; k < 1500; k++) begin
      @(posedge pclk);
      if (got.size() > 0 && dq_oe === 1'b0)
        break;
    end
    repeat (8) @(posedge pclk);
  endtask
  // Column 3 kept its first byte when the second write masked it
  task automatic burst(input logic [2:0] s, input logic ilv, input int n);
    logic [2:0] c, ib;
    chk32("beats", n, got.size());
    for (int i = 0; i < n && i < got.size(); i++) begin
      ib = 3'(i);
      c = ilv ? s ^ ib : {s[2] ^ ib[2], s[1:0] + ib[1:0]};
      chk32("beat", {24'h0, c == 3'h3 ? 8'h13 : 8'hA0 + c}, {24'h0, got[i]});
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    failures = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk32("cfg", 32'h000C_1000, rdat);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk32("stat", 32'h0001_0000, rdat);
    apb(1'b0, 12'h00C, 32'h0);
    chk32("unmapped", 32'h1, {31'h0, rerr});
    i_ctl.cmd(1'b0, 1'b1, 3'h1, 4'h0, 14'h0000);
    i_ctl.cmd(1'b0, 1'b0, 3'h0, 4'h5, 14'h0002);
    i_ctl.cmd(1'b0, 1'b0, 3'h5, 4'h6, 14'h0001);
    apb(1'b0, 12'h004, 32'h0);
    chk32("open", 32'h0001_0060, rdat);
    i_ctl.wr(4'h5, 14'h1000, 64'h1716_1514_1312_1110, 8'hFF);
    i_ctl.wr(4'h5, 14'h1000, 64'hA7A6_A5A4_A3A2_A1A0, 8'hF7);
    rd(1'b0, 4'h5, 14'h1000);
    burst(3'h0, 1'b0, 8);
    chk32("pre one", 32'h8, 32'((rise_t - pre_t) / 40));
    rd(1'b0, 4'h5, 14'h1005);
    burst(3'h5, 1'b0, 8);
    apb(1'b1, 12'h000, 32'h000C_1009);
    rd(1'b0, 4'h5, 14'h1005);
    burst(3'h5, 1'b1, 8);
    chk32("pre two", 32'h10, 32'((rise_t - pre_t) / 40));
    apb(1'b1, 12'h000, 32'h000C_1004);
    rd(1'b0, 4'h5, 14'h0000);
    burst(3'h0, 1'b0, 4);
    rd(1'b0, 4'h5, 14'h1000);
    burst(3'h0, 1'b0, 8);
    apb(1'b1, 12'h000, 32'h000C_1002);
    rd(1'b0, 4'h5, 14'h1000);
    burst(3'h0, 1'b0, 4);
    for (int al = 0; al < 3; al++) begin
      apb(1'b1, 12'h000, 32'h000C_1000 | (32'(al) << 4));
      rd(1'b0, 4'h5, 14'h1000);
      lat[al] = int'((rise_t - i_ctl.cmd_t) / 40);
    end
    chk32("lat minus one", 32'h78, lat[1] - lat[0]);
    chk32("lat minus two", 32'h70, lat[2] - lat[0]);
    apb(1'b1, 12'h000, 32'h000C_1000);
    apb(1'b0, 12'h008, 32'h0);
    cnt0 = rdat[15:0];
    rd(1'b1, 4'h6, 14'h1000);
    chk32("deselected beats", 32'h0, got.size());
    apb(1'b0, 12'h008, 32'h0);
    chk32("accepted", {16'h0, cnt0}, {16'h0, rdat[15:0]});
    rd(1'b0, 4'h5, 14'h1400);
    burst(3'h0, 1'b0, 8);
    apb(1'b0, 12'h004, 32'h0);
    chk32("auto close", 32'h0001_0040, rdat);
    rd(1'b0, 4'h5, 14'h1000);
    chk32("closed beats", 32'h0, got.size());
    end_sim();
  end
endmodule
